// >>> hw/mii_phy_pkg.sv
// Constants and types shared by the PHY-side media independent interface.
// Assumes a single 50 MHz system clock drives all logic.
package mii_phy_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ   = 50_000_000;
    localparam int unsigned MII_HZ_100   = 25_000_000;
    localparam int unsigned MII_HZ_10    = 2_500_000;
    // Half periods of the generated nibble clocks, in system cycles
    localparam int unsigned HALF_100     = SYS_CLK_HZ / (2 * MII_HZ_100);
    localparam int unsigned HALF_10      = SYS_CLK_HZ / (2 * MII_HZ_10);
    localparam int unsigned DIV_W        = 8;
    // Heartbeat pulse length
    localparam int unsigned SQE_NS       = 1000;
    localparam int unsigned SQE_CYC      = (SQE_NS * (SYS_CLK_HZ / 1_000_000)) / 1000;
    localparam int unsigned SQE_W        = 8;

    // ------------------------------------------------------------
    // Management frame layout
    // ------------------------------------------------------------
    localparam int unsigned PRE_BITS     = 32;
    localparam int unsigned CMD_BITS     = 13;  // ST second bit, op, phy, reg
    localparam int unsigned DATA_BITS    = 16;
    localparam int unsigned CNT_W        = 6;
    localparam logic [1:0]  OP_READ      = 2'h2;
    localparam logic [1:0]  OP_WRITE     = 2'h1;
    localparam int unsigned ST_POS       = 12;
    localparam int unsigned OP_HI        = 11;
    localparam int unsigned OP_LO        = 10;
    localparam int unsigned PHY_HI       = 9;
    localparam int unsigned PHY_LO       = 5;
    localparam int unsigned REG_HI       = 4;

    // Management frame states
    typedef enum logic [3:0] {
        MG_PRE  = 4'h1,
        MG_CMD  = 4'h2,
        MG_TA   = 4'h4,
        MG_DATA = 4'h8
    } mgmt_state_t;

endpackage

// >>> hw/rx_skid_buf.sv
// Two-entry valid/ready buffer for the receive nibble path.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module rx_skid_buf #(
    parameter int unsigned WIDTH = 5,
    parameter int unsigned DEPTH = 2
) (
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr;
        logic [PW-1:0]               rd;
        logic [PW:0]                 cnt;
        logic                        rdy;
    } buf_state_t;

    buf_state_t st_q;
    buf_state_t st_d;
    logic       push;
    logic       pop;

    // ------------------------------------------------------------
    // Pointer and count update
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        push = in_valid && in_ready;
        pop  = out_valid && out_ready;
        if (push) begin
            st_d.mem[st_q.wr] = in_data;
            st_d.wr = (st_q.wr == PW'(DEPTH - 1)) ? '0 : st_q.wr + 1'b1;
        end
        if (pop) begin
            st_d.rd = (st_q.rd == PW'(DEPTH - 1)) ? '0 : st_q.rd + 1'b1;
        end
        if (push && !pop) begin
            st_d.cnt = st_q.cnt + 1'b1;
        end else if (pop && !push) begin
            st_d.cnt = st_q.cnt - 1'b1;
        end
        // Ready registered so the port comes from a flop
        st_d.rdy = (st_d.cnt != (PW+1)'(DEPTH));
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            // Empty buffer accepts from reset on
            st_q     <= '0;
            st_q.rdy <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // Ready from a flop, valid and data from state
    assign in_ready  = st_q.rdy;
    assign out_valid = (st_q.cnt != '0);
    assign out_data  = st_q.mem[st_q.rd];

endmodule // rx_skid_buf
`default_nettype wire

// >>> hw/mii_phy_port.sv
// PHY side of the media independent interface: nibble clocks, transmit
// and receive paths, carrier and collision, and management serial port.
// Assumes line-side logic supplies receive nibbles and medium state
// synchronous to sys_clk; management registers live outside.
//
// Functional notes
// - The management port works with a management clock unrelated to the nibble clocks.
// - The management data line is shared and each side releases it while the other drives.
// - The transmit clock is derived from the reference, 25 MHz at 100 Mb/s and 2.5 MHz at 10 Mb/s.
// - The receive clock runs at 25 MHz at 100 Mb/s and 2.5 MHz at 10 Mb/s.
// - Receive data valid is high exactly in cycles carrying a valid received nibble.
// - Receive nibbles follow the receive clock and mean something only while data valid is high.
// - At 100 Mb/s receive error changes with the falling edge of the receive clock on an invalid symbol in a packet.
// - Carrier sense is high while the medium is not idle and low while it is idle.
// - In half duplex collision is high while transmit and receive are both active.
// - At 10 Mb/s half duplex with heartbeat on, collision pulses for about 1 us starting as transmit ends.
// - In full duplex collision stays low and no heartbeat is produced.
// - Reset reinitialises all internal state to its defaults.
`timescale 1ns/100ps
`default_nettype none
module mii_phy_port
    import mii_phy_pkg::*;
#(
    parameter int unsigned BUF_DEPTH = 2
) (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // Mode straps and configuration
    input  wire logic        speed_100,
    input  wire logic        full_duplex,
    input  wire logic        heartbeat_en,
    input  wire logic [4:0]  phy_addr,
    // MAC transmit side
    output logic             tx_clk,
    input  wire logic        tx_en,
    input  wire logic [3:0]  txd,
    // MAC receive side
    output logic             rx_clk,
    output logic             rx_dv,
    output logic             rx_er,
    output logic [3:0]       rxd,
    output logic             crs,
    output logic             col,
    // Management pins
    input  wire logic        mdc,
    input  wire logic        mdio_i,
    output logic             mdio_o,
    output logic             mdio_oe,
    // Line side transmit
    output logic [3:0]       line_tx_data,
    output logic             line_tx_valid,
    // Line side receive
    input  wire logic [3:0]  line_rx_data,
    input  wire logic        line_rx_sym_err,
    input  wire logic        line_rx_valid,
    output logic             line_rx_ready,
    input  wire logic        line_medium_busy,
    // Management register access
    output logic [4:0]       mgmt_addr,
    output logic [15:0]      mgmt_wr_data,
    output logic             mgmt_wr,
    input  wire logic [15:0] mgmt_rd_data
);

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic             nclk;
        logic [3:0]       tx_data;
        logic             tx_valid;
        logic             tx_act;
        logic [3:0]       rxd;
        logic             rx_dv;
        logic             rx_er;
        logic             crs;
        logic             col;
        logic [SQE_W-1:0] sqe;
        logic             mdc_s1;
        logic             mdc_s2;
        logic             mdc_s3;
        logic             mdi_s1;
        logic             mdi_s2;
        mgmt_state_t      mg;
        logic [CNT_W-1:0] cnt;
        logic [15:0]      sh;
        logic             rd_op;
        logic             wr_op;
        logic             mdo;
        logic             mdoe;
        logic             wr;
        logic [4:0]       addr;
        logic [15:0]      wdat;
    } port_state_t;

    port_state_t st_q;
    port_state_t st_d;

    logic [DIV_W-1:0] half;
    logic             tick;
    logic             rise;
    logic             fall;
    logic             mrise;
    logic [4:0]       buf_in;
    logic [4:0]       buf_out;
    logic             buf_valid;

    // ------------------------------------------------------------
    // Receive buffer between line and MAC
    // ------------------------------------------------------------
    assign buf_in = {line_rx_sym_err, line_rx_data};

    rx_skid_buf #(
        .WIDTH (5),
        .DEPTH (BUF_DEPTH)
    ) u_rx_buf (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .in_data   (buf_in),
        .in_valid  (line_rx_valid),
        .in_ready  (line_rx_ready),
        .out_data  (buf_out),
        .out_valid (buf_valid),
        .out_ready (fall)
    );

    // Divider strobes and synchronised management clock edge
    assign half  = speed_100 ? DIV_W'(HALF_100) : DIV_W'(HALF_10);
    assign tick  = (st_q.div >= half - 1'b1);
    assign rise  = tick && !st_q.nclk;
    assign fall  = tick && st_q.nclk;
    assign mrise = st_q.mdc_s2 && !st_q.mdc_s3;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.div = tick ? '0 : st_q.div + 1'b1;
        if (tick) begin
            st_d.nclk = !st_q.nclk;
        end

        if (rise) begin
            st_d.tx_valid = tx_en;
            st_d.tx_data  = tx_en ? txd : 4'h0;
            st_d.tx_act   = tx_en;
        end

        if (fall) begin
            st_d.rx_dv = buf_valid;
            st_d.rxd   = buf_valid ? buf_out[3:0] : 4'h0;
            st_d.rx_er = buf_valid && buf_out[4] && speed_100;
        end

        st_d.crs = line_medium_busy;

        if (st_q.tx_act && rise && !tx_en && !speed_100 && heartbeat_en) begin
            st_d.sqe = SQE_W'(SQE_CYC);
        end else if (st_q.sqe != '0) begin
            st_d.sqe = st_q.sqe - 1'b1;
        end
        if (full_duplex) begin
            st_d.col = 1'b0;
            st_d.sqe = '0;
        end else begin
            st_d.col = (st_q.tx_act && line_medium_busy) || (st_q.sqe != '0);
        end

        st_d.mdc_s1 = mdc;
        st_d.mdc_s2 = st_q.mdc_s1;
        st_d.mdc_s3 = st_q.mdc_s2;
        st_d.mdi_s1 = mdio_i;
        st_d.mdi_s2 = st_q.mdi_s1;
        st_d.wr     = 1'b0;

        if (mrise) begin
            case (st_q.mg)
                MG_PRE: begin
                    if (st_q.mdi_s2) begin
                        if (st_q.cnt < CNT_W'(PRE_BITS)) begin
                            st_d.cnt = st_q.cnt + 1'b1;
                        end
                    end else if (st_q.cnt >= CNT_W'(PRE_BITS)) begin
                        st_d.mg  = MG_CMD;
                        st_d.cnt = '0;
                    end else begin
                        st_d.cnt = '0;
                    end
                end
                MG_CMD: begin
                    st_d.sh  = {st_q.sh[14:0], st_q.mdi_s2};
                    st_d.cnt = st_q.cnt + 1'b1;
                    if (st_q.cnt == CNT_W'(CMD_BITS - 1)) begin
                        st_d.mg    = MG_TA;
                        st_d.cnt   = '0;
                        st_d.addr  = {st_q.sh[3:0], st_q.mdi_s2};
                        st_d.rd_op = st_q.sh[ST_POS-1] &&
                                     (st_q.sh[OP_HI-1:OP_LO-1] == OP_READ) &&
                                     (st_q.sh[PHY_HI-1:PHY_LO-1] == phy_addr);
                        st_d.wr_op = st_q.sh[ST_POS-1] &&
                                     (st_q.sh[OP_HI-1:OP_LO-1] == OP_WRITE) &&
                                     (st_q.sh[PHY_HI-1:PHY_LO-1] == phy_addr);
                    end
                end
                MG_TA: begin
                    st_d.cnt = st_q.cnt + 1'b1;
                    if (st_q.cnt == '0) begin
                        st_d.mdoe = st_q.rd_op;
                        st_d.mdo  = 1'b0;
                        st_d.sh   = mgmt_rd_data;
                    end else begin
                        st_d.mg  = MG_DATA;
                        st_d.cnt = '0;
                        st_d.mdo = st_q.rd_op && st_q.sh[15];
                        st_d.sh  = {st_q.sh[14:0], 1'b0};
                    end
                end
                MG_DATA: begin
                    st_d.cnt = st_q.cnt + 1'b1;
                    if (st_q.wr_op) begin
                        st_d.sh = {st_q.sh[14:0], st_q.mdi_s2};
                    end else begin
                        st_d.mdo = st_q.rd_op && st_q.sh[15];
                        st_d.sh  = {st_q.sh[14:0], 1'b0};
                    end
                    if (st_q.cnt == CNT_W'(DATA_BITS - 1)) begin
                        st_d.mdoe = 1'b0;
                        st_d.mdo  = 1'b0;
                        st_d.mg   = MG_PRE;
                        st_d.cnt  = '0;
                        st_d.wr   = st_q.wr_op;
                        st_d.wdat = {st_q.sh[14:0], st_q.mdi_s2};
                    end
                end
                default: begin
                    st_d.mg   = MG_PRE;
                    st_d.cnt  = '0;
                    st_d.mdoe = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_q    <= '0;
            st_q.mg <= MG_PRE;
        end else begin
            st_q <= st_d;
        end
    end

    assign tx_clk        = st_q.nclk;
    assign rx_clk        = st_q.nclk;
    assign rx_dv         = st_q.rx_dv;
    assign rx_er         = st_q.rx_er;
    assign rxd           = st_q.rxd;
    assign crs           = st_q.crs;
    assign col           = st_q.col;
    assign mdio_o        = st_q.mdo;
    assign mdio_oe       = st_q.mdoe;
    assign line_tx_data  = st_q.tx_data;
    assign line_tx_valid = st_q.tx_valid;
    assign mgmt_addr     = st_q.addr;
    assign mgmt_wr_data  = st_q.wdat;
    assign mgmt_wr       = st_q.wr;

endmodule // mii_phy_port
`default_nettype wire

// >>> test/mii_phy_port_checker.sv
// Concurrent checks on the ports of the PHY-side nibble port.
// Assumes one clock and a synchronous active-high reset; attached by bind.
`timescale 1ns/100ps
`default_nettype none
module mii_phy_port_checker (
    input wire logic       sys_clk,
    input wire logic       reset,
    input wire logic       speed_100,
    input wire logic       full_duplex,
    input wire logic       heartbeat_en,
    input wire logic       tx_clk,
    input wire logic       tx_en,
    input wire logic [3:0] txd,
    input wire logic       rx_clk,
    input wire logic       rx_dv,
    input wire logic       rx_er,
    input wire logic [3:0] rxd,
    input wire logic       crs,
    input wire logic       col,
    input wire logic       mdio_o,
    input wire logic       mdio_oe,
    input wire logic [3:0] line_tx_data,
    input wire logic       line_tx_valid,
    input wire logic       line_medium_busy,
    input wire logic       mgmt_wr
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // Ten-cycle high phase, heartbeat pulse start
    sequence s_hi10; ##9 tx_clk ##1 !tx_clk; endsequence
    sequence s_sqe; ##[0:2] col [*8]; endsequence
    AST_TX_CAPTURE: assert property ($rose(tx_clk) |-> line_tx_valid == $past(tx_en) &&
        line_tx_data == ($past(tx_en) ? $past(txd) : 4'h0)) else $error("tx capture wrong");
    AST_TX_100: assert property (
        $rose(tx_clk) && speed_100 |=> !tx_clk) else $error("fast tx clock wrong");
    AST_TX_10: assert property (
        $rose(tx_clk) && !speed_100 |-> s_hi10) else $error("slow tx clock wrong");
    AST_RX_CLK: assert property (
        rx_clk == tx_clk) else $error("rx clock differs");
    AST_RX_HOLD: assert property (
        !$fell(rx_clk) && !$past(reset) |-> $stable({rx_dv, rx_er, rxd}))
        else $error("rx moved off clock fall");
    AST_RX_IDLE: assert property (
        !rx_dv |-> rxd == 4'h0 && !rx_er) else $error("rx data without valid");
    AST_RX_ER: assert property (
        rx_er |-> speed_100 && rx_dv) else $error("rx error out of place");
    AST_CRS: assert property (
        !$past(reset) |-> crs == $past(line_medium_busy)) else $error("carrier wrong");
    AST_FD_COL: assert property (
        full_duplex && $past(full_duplex) |-> !col) else $error("col in full duplex");
    AST_SQE: assert property ($fell(line_tx_valid) && !speed_100 && !full_duplex &&
        heartbeat_en |-> s_sqe) else $error("heartbeat missing");
    AST_MDIO_TA: assert property (
        $rose(mdio_oe) |-> !mdio_o) else $error("turnaround not low");
    AST_WR_PULSE: assert property (
        mgmt_wr |=> !mgmt_wr) else $error("write pulse too long");
endmodule // mii_phy_port_checker
bind mii_phy_port mii_phy_port_checker u_chk (.sys_clk, .reset, .speed_100, .full_duplex,
    .heartbeat_en, .tx_clk, .tx_en, .txd, .rx_clk, .rx_dv, .rx_er, .rxd, .crs, .col, .mdio_o,
    .mdio_oe, .line_tx_data, .line_tx_valid, .line_medium_busy, .mgmt_wr);
`default_nettype wire

// >>> test/mii_mac_model.sv
// Behavioural MAC and station manager facing the PHY-side port.
// Assumes the port supplies the nibble clocks; mdio has a pull-up.
`timescale 1ns/100ps
`default_nettype none
module mii_mac_model
    import mii_phy_pkg::*;
(
    input  wire logic       tx_clk,
    output logic            tx_en,
    output logic [3:0]      txd,
    input  wire logic       rx_clk,
    input  wire logic       rx_dv,
    input  wire logic       rx_er,
    input  wire logic [3:0] rxd,
    output logic            mdc,
    input  wire logic       mdio_o,
    input  wire logic       mdio_oe,
    output logic            mdio_i
);
    // ----------------------------------------
    // Transmit, receive and management
    // ----------------------------------------
    logic       sm_oe = 1'h0;
    logic       sm_o = 1'h1;
    logic [4:0] rx_q[$];
    // Idle levels, clock stands low
    initial begin
        tx_en = 1'h0;
        txd = 4'h0;
        mdc = 1'h0;
    end
    assign mdio_i = mdio_oe ? mdio_o : (sm_oe ? sm_o : 1'h1);
    always @(posedge rx_clk) begin
        if (rx_dv)
            rx_q.push_back({rx_er, rxd});
    end
    task automatic send(input int n, input logic [3:0] base);
        for (int i = 0; i < n; i++) begin
            @(posedge tx_clk);
            #1;
            tx_en = 1'h1;
            txd = base + 4'(i);
        end
        @(posedge tx_clk);
        #1;
        tx_en = 1'h0;
        txd = ~txd;
    endtask
    task automatic bit_io(input logic b, input logic drv, output logic s);
        sm_oe = drv;
        sm_o = b;
        #97;
        s = mdio_i;
        mdc = 1'h1;
        #97;
        mdc = 1'h0;
    endtask
    task automatic frame(input logic [1:0] op, input logic [9:0] pr, input logic [15:0] wd,
                         output logic [15:0] rd, output logic ta);
        logic [45:0] hdr;
        logic        s;
        hdr = {32'hFFFFFFFF, 2'h1, op, pr};
        for (int i = 45; i >= 0; i--)
            bit_io(hdr[i], 1'h1, s);
        bit_io(1'h1, op == OP_WRITE, s);
        bit_io(1'h0, op == OP_WRITE, ta);
        for (int i = 15; i >= 0; i--) begin
            bit_io(wd[i], op == OP_WRITE, s);
            rd[i] = s;
        end
        sm_oe = 1'h0;
    endtask
endmodule // mii_mac_model
`default_nettype wire

// >>> test/phy_mii_mac_side_interface_test.sv
// Self-checking bench for the PHY-side nibble port with a MAC model.
// Assumes the package, port, checker and MAC model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin \
    n_mismatch++; $display("[ERR] %s exp %0h got %0h", nm, exp, got); end end
module phy_mii_mac_side_interface_test
    import mii_phy_pkg::*;
();
    // ----------------------------------------
    // Signals, instances and monitors
    // ----------------------------------------
    logic        sys_clk = 1'h0;
    logic        reset, speed_100, full_duplex, heartbeat_en, tx_clk, tx_en, rx_clk, rx_dv;
    logic        rx_er, crs, col, mdc, mdio_i, mdio_o, mdio_oe, line_tx_valid, line_rx_sym_err;
    logic        line_rx_valid, line_rx_ready, line_medium_busy, mgmt_wr, tx_seen, stalled, ta;
    logic [3:0]  txd, rxd, line_tx_data, line_rx_data;
    logic [4:0]  phy_addr, mgmt_addr;
    logic [15:0] mgmt_wr_data, mgmt_rd_data, rd;
    logic [20:0] wr_seen;
    logic [3:0]  txq[$];
    int          n_mismatch = 0, samples_checked = 0, wr_cnt = 0, g, cnt;
    mii_phy_port #(.BUF_DEPTH(2)) dut (.sys_clk, .reset, .speed_100, .full_duplex,
        .heartbeat_en, .phy_addr, .tx_clk, .tx_en, .txd, .rx_clk, .rx_dv, .rx_er, .rxd, .crs,
        .col, .mdc, .mdio_i, .mdio_o, .mdio_oe, .line_tx_data, .line_tx_valid, .line_rx_data,
        .line_rx_sym_err, .line_rx_valid, .line_rx_ready, .line_medium_busy, .mgmt_addr,
        .mgmt_wr_data, .mgmt_wr, .mgmt_rd_data);
    mii_mac_model mac (.tx_clk, .tx_en, .txd, .rx_clk, .rx_dv, .rx_er, .rxd, .mdc, .mdio_o,
        .mdio_oe, .mdio_i);
    always #10 sys_clk = ~sys_clk;
    // Nibbles handed to the line, write pulses
    always @(posedge sys_clk) begin
        if (tx_clk && !tx_seen && line_tx_valid)
            txq.push_back(line_tx_data);
        tx_seen <= tx_clk;
        if (mgmt_wr) begin
            wr_cnt++;
            wr_seen = {mgmt_addr, mgmt_wr_data};
        end
    end
    task automatic wrap_up();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic do_reset(input logic sp, input logic fd, input logic hb);
        {reset, speed_100, full_duplex, heartbeat_en} = {1'h1, sp, fd, hb};
        repeat (3) @(posedge sys_clk);
        #1;
        reset = 1'h0;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_idle();
        do_reset(1'h1, 1'h0, 1'h0);
        `CHK("idle", 7'h01, {rx_dv, rx_er, crs, col, mdio_oe, line_tx_valid, line_rx_ready})
    endtask
    task automatic t_tx(input logic sp);
        do_reset(sp, 1'h0, 1'h0);
        txq.delete();
        mac.send(4, 4'hC);
        repeat (3) @(posedge tx_clk);
        #1;
        `CHK("tx count", 4, txq.size())
        foreach (txq[i]) `CHK("tx nibble", 4'hC + 4'(i), txq[i])
    endtask
    task automatic t_rx(input logic sp);
        do_reset(sp, 1'h0, 1'h0);
        mac.rx_q.delete();
        stalled = 1'h0;
        line_rx_valid = 1'h1;
        for (int i = 0; i < 3; i++) begin
            {line_rx_sym_err, line_rx_data} = {i == 1, 4'h5 + 4'(i)};
            g = 0;
            do begin
                @(posedge sys_clk);
                stalled |= !line_rx_ready;
                g++;
            end while (!line_rx_ready && g < 100);
            #1;
        end
        {line_rx_valid, line_rx_data} = {1'h0, ~line_rx_data};
        for (g = 0; g < 200 && mac.rx_q.size() < 3; g++) @(posedge sys_clk);
        repeat (2 * HALF_10 + 2) @(posedge sys_clk);
        #1;
        `CHK("rx count", 3, mac.rx_q.size())
        foreach (mac.rx_q[i]) `CHK("rx word", {sp & (i == 1), 4'h5 + 4'(i)}, mac.rx_q[i])
        if (!sp) `CHK("rx stall", 1'h1, stalled)
        `CHK("rx idle", 1'h0, rx_dv)
    endtask
    task automatic t_col();
        for (int fd = 0; fd < 2; fd++) begin
            do_reset(1'h1, fd == 1, 1'h0);
            line_medium_busy = 1'h1;
            fork
                mac.send(8, 4'h2);
                begin
                    repeat (8) @(posedge sys_clk);
                    #1;
                    `CHK("col busy", fd == 0, col)
                    `CHK("crs busy", 1'h1, crs)
                end
            join
            line_medium_busy = 1'h0;
            repeat (2) @(posedge sys_clk);
            #1;
            `CHK("quiet", 2'h0, {crs, col})
        end
    endtask
    task automatic t_sqe();
        for (int k = 0; k < 3; k++) begin
            do_reset(1'h0, k == 1, k != 2);
            mac.send(2, 4'h3);
            cnt = 0;
            repeat (200) begin
                @(posedge sys_clk);
                #1;
                cnt += (col !== 1'h0);
            end
            `CHK("sqe len", (k == 0) ? int'(SQE_CYC) : 0, cnt)
        end
    endtask
    task automatic t_mgmt();
        do_reset(1'h1, 1'h0, 1'h0);
        mac.frame(OP_WRITE, {5'h0B, 5'h1D}, 16'h9E61, rd, ta);
        repeat (4) @(posedge sys_clk);
        #1;
        `CHK("wr word", {5'h1D, 16'h9E61}, wr_seen)
        mac.frame(OP_READ, {5'h0B, 5'h04}, 16'h0000, rd, ta);
        `CHK("rd data", 17'h0C3A5, {ta, rd})
        mac.frame(OP_READ, {5'h0C, 5'h04}, 16'h0000, rd, ta);
        `CHK("other phy", 17'h1FFFF, {ta, rd})
        mac.frame(2'h3, {5'h0B, 5'h04}, 16'h0000, rd, ta);
        `CHK("bad op", 17'h1FFFF, {ta, rd})
        mac.frame(OP_WRITE, {5'h0C, 5'h02}, 16'h1234, rd, ta);
        repeat (4) @(posedge sys_clk);
        #1;
        `CHK("wr count", 1, wr_cnt)
    endtask
    // Hang guard
    initial begin
        #1_000_000;
        n_mismatch++;
        wrap_up();
    end
    // Main sequence
    initial begin
        {line_rx_valid, line_rx_sym_err, line_medium_busy} = 3'h0;
        {phy_addr, mgmt_rd_data, line_rx_data} = {5'h0B, 16'hC3A5, 4'h0};
        t_idle();
        t_tx(1'h1);
        t_tx(1'h0);
        t_rx(1'h1);
        t_rx(1'h0);
        t_col();
        t_sqe();
        t_mgmt();
        t_idle();
        wrap_up();
    end
endmodule // phy_mii_mac_side_interface_test
`default_nettype wire
